// ===== shared/ifs_regs.vh
/*
  Register map, field positions, limits, lamp drive and filter constants of the infeed
  fault supervisor.
  Assumes measured values arrive already scaled in the units named below.
*/
`ifndef IFS_REGS_VH
`define IFS_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define IFS_ADDR_CTRL 12'h000
`define IFS_ADDR_LAMP 12'h004
`define IFS_ADDR_STAT 12'h008
`define IFS_ADDR_CODE 12'h00c
`define IFS_ADDR_CURR 12'h010
`define IFS_ADDR_PWR 12'h014
`define IFS_ADDR_W 12

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define IFS_CTRL_EN 0
`define IFS_CTRL_HI_RATING 1

// ----------------------------------------------------------------------
// Status register bit positions: errors at error number minus one (bits 0 to 18), state flags at bits 24 to 26
// ----------------------------------------------------------------------
`define IFS_ST_SUPPLY 0
`define IFS_ST_BRK_SHORT 1
`define IFS_ST_BRK_TEMP 2
`define IFS_ST_PHASE 3
`define IFS_ST_OVERCUR 4
`define IFS_ST_OVERV 5
`define IFS_ST_UNDERV 6
`define IFS_ST_RECT_T 7
`define IFS_ST_SINK_T 8
`define IFS_ST_GRID 9
`define IFS_ST_FREQ 10
`define IFS_ST_BRK_TEST 11
`define IFS_ST_OVERLOAD 12
`define IFS_ST_GND 13
`define IFS_ST_LOPEN 14
`define IFS_ST_LSHORT 15
`define IFS_ST_PRECHG 16
`define IFS_ST_RESID 17
`define IFS_ST_FAN 18
`define IFS_ST_RECT_ON 24
`define IFS_ST_READY 25
`define IFS_ST_ENABLED 26
`define IFS_NERR 19
`define IFS_STOP_MASK 19'h11fff
`define IFS_LATCH_MASK 19'h31fff
`define IFS_DISCH_MASK 19'h31ffd

// ----------------------------------------------------------------------
// Limits: volts, amps, deg C, 0.1 V, 0.1 Hz
// ----------------------------------------------------------------------
`define IFS_SINK_TRIP_C 16'sd70
`define IFS_RECT_TRIP_C 16'sd115
`define IFS_SUP_LO_DV 16'sd190
`define IFS_SUP_HI_DV 16'sd290
`define IFS_FREQ_LO_DHZ 16'sd470
`define IFS_FREQ_HI_DHZ 16'sd640
`define IFS_OC_HI_15 16'sd130
`define IFS_OC_LO_15 -16'sd50
`define IFS_OC_HI_24 16'sd240
`define IFS_OC_LO_24 -16'sd100
`define IFS_OVERV_V 16'sd900
`define IFS_UNDERV_V 16'sd320
`define IFS_OL_15 16'sd31
`define IFS_OL_24 16'sd50
`define IFS_LOWV_V 16'sd50

// ----------------------------------------------------------------------
// Lamp drive and measurement filter
// ----------------------------------------------------------------------
`define IFS_LAMP_FULL_UA 20000
`define IFS_LAMP_TEST_CMD 8'h80
`define IFS_FILT_SHIFT 6
`endif

// ===== verilog/ifs_supervisor.v
/*
  Infeed fault supervisor: compares scaled measurements with fixed limits,
  latches the first error, drives gating/discharge, lamp test and an
  AHB-Lite register slave.
  Assumes synchronous inputs on clk_sys_in and one AHB master.
*/
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "ifs_regs.vh"

module ifs_supervisor #(
  parameter CLK_HZ = 125000000,
  parameter TEST_MS = 200,
  parameter TEST_CYC = CLK_HZ / 1000 * TEST_MS,
  parameter DISCH_MS = 3000,
  parameter DISCH_CYC = CLK_HZ / 1000 * DISCH_MS,
  parameter OL_CYC = 125000000
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire hreadyout_out,
  output wire hresp_out,
  output reg [31:0] hrdata_out,
  input wire signed [15:0] bus_volt_in,
  input wire signed [15:0] bus_curr_in,
  input wire signed [15:0] sink_temp_in,
  input wire signed [15:0] rect_temp_in,
  input wire signed [15:0] supply_dv_in,
  input wire signed [15:0] freq_dhz_in,
  input wire phase_unknown_in,
  input wire grid_lost_in,
  input wire fan_fault_in,
  input wire gnd_fault_in,
  input wire brake_short_in,
  input wire brake_temp_in,
  input wire brake_test_fail_in,
  input wire brake_test_done_in,
  input wire charging_in,
  input wire gating_full_in,
  input wire lamp_open_in,
  input wire lamp_short_in,
  output reg rect_gate_out,
  output reg discharge_out,
  output reg ready_out,
  output reg [14:0] lamp_current_ua_out,
  output reg lamp_test_out
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [1:0] ctrl_ff;
  reg [7:0] lamp_brightness_cmd_ff;
  reg en_prev_ff;
  reg [`IFS_NERR-1:0] err_ff;
  reg [`IFS_NERR-1:0] nxt_err;
  reg [31:0] ol_cnt_ff;
  reg [31:0] disch_cnt_ff;
  reg disch_run_ff;
  reg [31:0] test_cnt_ff;
  reg [7:0] lamp_prev_ff;
  reg signed [31:0] curr_acc_ff;
  reg signed [31:0] pwr_acc_ff;
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg [`IFS_ADDR_W-1:0] addr_ff;

  wire en = ctrl_ff[`IFS_CTRL_EN];
  wire hi_rating = ctrl_ff[`IFS_CTRL_HI_RATING];
  wire en_rise = en & ~en_prev_ff;
  wire signed [15:0] curr_f = curr_acc_ff[`IFS_FILT_SHIFT+15:`IFS_FILT_SHIFT];
  wire signed [15:0] pwr_f = pwr_acc_ff[`IFS_FILT_SHIFT+15:`IFS_FILT_SHIFT];
  wire [31:0] test_len = TEST_CYC;
  wire [31:0] disch_len = DISCH_CYC;
  wire [31:0] ol_len = OL_CYC;

  function in_window;
    input signed [15:0] v;
    input signed [15:0] lo;
    input signed [15:0] hi;
    begin
      in_window = (v >= lo) && (v <= hi);
    end
  endfunction

  // --------------------------------------------------------------------
  // Fault detection
  // --------------------------------------------------------------------
  reg [`IFS_NERR-1:0] raw;
  wire ol_over = hi_rating ? (bus_curr_in > `IFS_OL_24) :
    (bus_curr_in > `IFS_OL_15);
  always @* begin
    raw = {`IFS_NERR{1'b0}};
    raw[`IFS_ST_SINK_T] = sink_temp_in > `IFS_SINK_TRIP_C;
    raw[`IFS_ST_RECT_T] = rect_temp_in > `IFS_RECT_TRIP_C;
    raw[`IFS_ST_FAN] = fan_fault_in;
    raw[`IFS_ST_SUPPLY] = ~in_window(supply_dv_in, `IFS_SUP_LO_DV,
      `IFS_SUP_HI_DV);
    raw[`IFS_ST_FREQ] = en & ~in_window(freq_dhz_in, `IFS_FREQ_LO_DHZ,
      `IFS_FREQ_HI_DHZ);
    raw[`IFS_ST_OVERCUR] = hi_rating ?
      ~in_window(bus_curr_in, `IFS_OC_LO_24, `IFS_OC_HI_24) :
      ~in_window(bus_curr_in, `IFS_OC_LO_15, `IFS_OC_HI_15);
    raw[`IFS_ST_OVERV] = bus_volt_in > `IFS_OVERV_V;
    raw[`IFS_ST_UNDERV] = ready_out & (bus_volt_in < `IFS_UNDERV_V);
    raw[`IFS_ST_OVERLOAD] = ol_over && (ol_cnt_ff >= ol_len);
    raw[`IFS_ST_PRECHG] = en & ~charging_in & ~rect_gate_out &
      ~ready_out & (bus_volt_in > `IFS_LOWV_V);
    raw[`IFS_ST_RESID] = disch_run_ff && (disch_cnt_ff == disch_len) &&
      (bus_volt_in > `IFS_LOWV_V);
    raw[`IFS_ST_PHASE] = en & phase_unknown_in;
    raw[`IFS_ST_GRID] = en & grid_lost_in;
    raw[`IFS_ST_BRK_SHORT] = brake_short_in;
    raw[`IFS_ST_BRK_TEMP] = brake_temp_in;
    raw[`IFS_ST_BRK_TEST] = brake_test_fail_in;
    raw[`IFS_ST_GND] = en & gnd_fault_in;
  end

  // Lowest error number wins when several rise together.
  wire [`IFS_NERR-1:0] cand = raw & `IFS_LATCH_MASK;
  wire [`IFS_NERR-1:0] first = cand & (~cand + 1'b1);
  wire any_latched = |(err_ff & `IFS_LATCH_MASK);

  always @* begin
    nxt_err = err_ff;
    if (en_rise) begin
      nxt_err = {`IFS_NERR{1'b0}};
    end else if (en | disch_run_ff) begin
      if (!any_latched) begin
        nxt_err = err_ff | first;
      end
    end
    // Warnings track their condition; lamp bits handled below.
    nxt_err[`IFS_ST_FAN] = raw[`IFS_ST_FAN];
    nxt_err[`IFS_ST_GND] = raw[`IFS_ST_GND];
    nxt_err[`IFS_ST_LOPEN] = err_ff[`IFS_ST_LOPEN];
    nxt_err[`IFS_ST_LSHORT] = err_ff[`IFS_ST_LSHORT];
    if (lamp_test_out & lamp_open_in) begin
      nxt_err[`IFS_ST_LOPEN] = 1'b1;
    end
    if (lamp_test_out & lamp_short_in) begin
      nxt_err[`IFS_ST_LSHORT] = 1'b1;
    end
    if (lamp_prev_ff == 8'h00 && lamp_brightness_cmd_ff != 8'h00 &&
        !lamp_test_out) begin
      nxt_err[`IFS_ST_LOPEN] = 1'b0;
      nxt_err[`IFS_ST_LSHORT] = 1'b0;
    end
  end

  wire stop = |(nxt_err & `IFS_STOP_MASK);
  wire disch_err = |(nxt_err & `IFS_DISCH_MASK);

  // --------------------------------------------------------------------
  // Sequencing, counters and outputs
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_prev_ff <= 1'b0;
      err_ff <= {`IFS_NERR{1'b0}};
      ol_cnt_ff <= 32'h0;
      disch_cnt_ff <= 32'h0;
      disch_run_ff <= 1'b0;
      rect_gate_out <= 1'b0;
      discharge_out <= 1'b1;
      ready_out <= 1'b0;
      curr_acc_ff <= 32'sh0;
      pwr_acc_ff <= 32'sh0;
    end else begin
      en_prev_ff <= en;
      err_ff <= nxt_err;
      if (ol_over) begin
        if (ol_cnt_ff < ol_len) begin
          ol_cnt_ff <= ol_cnt_ff + 32'h1;
        end
      end else begin
        ol_cnt_ff <= 32'h0;
      end
      if (en_prev_ff & ~en) begin
        disch_run_ff <= 1'b1;
        disch_cnt_ff <= 32'h0;
      end else if (disch_run_ff) begin
        if (disch_cnt_ff == disch_len) begin
          disch_run_ff <= 1'b0;
        end else begin
          disch_cnt_ff <= disch_cnt_ff + 32'h1;
        end
      end
      rect_gate_out <= en & ~stop & ~disch_run_ff &
        (charging_in | gating_full_in);
      discharge_out <= ~en | disch_run_ff | disch_err;
      ready_out <= en & ~stop & brake_test_done_in & gating_full_in &
        rect_gate_out;
      // First-order low-pass removes mains ripple, sign kept.
      curr_acc_ff <= curr_acc_ff + $signed({{16{bus_curr_in[15]}},
        bus_curr_in}) - (curr_acc_ff >>> `IFS_FILT_SHIFT);
      pwr_acc_ff <= pwr_acc_ff + (bus_volt_in * bus_curr_in >>> 10) -
        (pwr_acc_ff >>> `IFS_FILT_SHIFT);
    end
  end

  // --------------------------------------------------------------------
  // Lamp drive with open/short test pulse
  // --------------------------------------------------------------------
  wire [7:0] lamp_level = lamp_test_out ? `IFS_LAMP_TEST_CMD :
    lamp_brightness_cmd_ff;
  wire [31:0] lamp_prod = lamp_level * `IFS_LAMP_FULL_UA;
  wire [31:0] lamp_quot = lamp_prod / 32'd255;

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lamp_prev_ff <= 8'h00;
      test_cnt_ff <= 32'h0;
      lamp_test_out <= 1'b0;
      lamp_current_ua_out <= 15'h0000;
    end else begin
      lamp_prev_ff <= lamp_brightness_cmd_ff;
      if (lamp_prev_ff == 8'h00 && lamp_brightness_cmd_ff != 8'h00) begin
        lamp_test_out <= 1'b1;
        test_cnt_ff <= 32'h0;
      end else if (lamp_test_out) begin
        if (test_cnt_ff == test_len - 32'h1) begin
          lamp_test_out <= 1'b0;
        end else begin
          test_cnt_ff <= test_cnt_ff + 32'h1;
        end
      end
      if (lamp_brightness_cmd_ff == 8'h00) begin
        lamp_test_out <= 1'b0;
      end
      lamp_current_ua_out <= lamp_quot[14:0];
    end
  end

  // --------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------------------------
  wire take = hsel_in & htrans_in[1] & hready_in;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= {`IFS_ADDR_W{1'b0}};
      ctrl_ff <= 2'h0;
      lamp_brightness_cmd_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take & hwrite_in;
      rd_pend_ff <= take & ~hwrite_in;
      if (take) begin
        addr_ff <= haddr_in[`IFS_ADDR_W-1:0];
      end
      if (wr_pend_ff) begin
        case (addr_ff)
          `IFS_ADDR_CTRL: ctrl_ff <= hwdata_in[1:0];
          `IFS_ADDR_LAMP: lamp_brightness_cmd_ff <= hwdata_in[7:0];
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // Read data is registered off the address phase so it stands in the
  // data phase; status bits are live each read.
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hrdata_out <= 32'h0;
    end else if (take & ~hwrite_in) begin
      case (haddr_in[`IFS_ADDR_W-1:0])
        `IFS_ADDR_CTRL: hrdata_out <= {30'h0, ctrl_ff};
        `IFS_ADDR_LAMP: hrdata_out <= {24'h0, lamp_brightness_cmd_ff};
        `IFS_ADDR_STAT: hrdata_out <= {5'h0, en, ready_out, rect_gate_out,
          5'h0, err_ff};
        `IFS_ADDR_CODE: hrdata_out <= {17'h0, lamp_current_ua_out};
        `IFS_ADDR_CURR: hrdata_out <= {{16{curr_f[15]}}, curr_f};
        `IFS_ADDR_PWR: hrdata_out <= {{16{pwr_f[15]}}, pwr_f};
        default: hrdata_out <= 32'h0;
      endcase
    end
  end

endmodule

// ===== testbench/ifs_checker_assertions.sv
/*
  Port checker of the infeed fault supervisor, bound into the design.
  Assumes the 15 kW rating, so the fixed limits below apply.
*/
`timescale 1ns/100ps
module ifs_checker #(
  parameter TEST_CYC = 20
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire signed [15:0] bus_volt_in,
  input wire signed [15:0] sink_temp_in,
  input wire signed [15:0] freq_dhz_in,
  input wire rect_gate_out,
  input wire discharge_out,
  input wire ready_out,
  input wire [14:0] lamp_current_ua_out,
  input wire lamp_test_out
);
  // ----------------------------------------------------------------------
  // Helper logic and properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  reg [31:0] test_cnt_ff;
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) test_cnt_ff <= 32'h0;
    else if (lamp_test_out) test_cnt_ff <= test_cnt_ff + 32'h1;
    else test_cnt_ff <= 32'h0;
  end
  a_bus_always_ok: assert property (hreadyout_out && !hresp_out)
    else $error("bus slave stalled or answered an error");
  a_ready_gated: assert property (ready_out |-> rect_gate_out)
    else $error("ready without rectifier gating");
  a_overv_stops: assert property ((ready_out && bus_volt_in > 16'sd900) |->
    ##[1:3] (!rect_gate_out && discharge_out))
    else $error("over-voltage did not stop and discharge");
  a_underv_stops: assert property ((ready_out && bus_volt_in < 16'sd320) |->
    ##[1:3] !rect_gate_out) else $error("under-voltage did not stop");
  a_sink_discharges: assert property ((ready_out &&
    sink_temp_in > 16'sd70) |-> ##[1:3] discharge_out)
    else $error("heatsink trip did not discharge");
  a_freq_stops: assert property ((ready_out && (freq_dhz_in < 16'sd470 ||
    freq_dhz_in > 16'sd640)) |-> ##[1:3] !rect_gate_out)
    else $error("frequency trip did not stop");
  a_test_half: assert property ((lamp_test_out && $past(lamp_test_out)) |->
    lamp_current_ua_out == 15'd10039) else $error("test pulse level wrong");
  a_test_length: assert property (test_cnt_ff < TEST_CYC + 2)
    else $error("test pulse too long");
  a_lamp_ceiling: assert property (lamp_current_ua_out <= 15'd20000)
    else $error("lamp current above full scale");
  cover property ($rose(ready_out));
  cover property ($rose(lamp_test_out));
  cover property ($fell(rect_gate_out) && discharge_out);
endmodule
bind ifs_supervisor ifs_checker #(.TEST_CYC(TEST_CYC)) u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .bus_volt_in(bus_volt_in), .sink_temp_in(sink_temp_in),
  .freq_dhz_in(freq_dhz_in), .rect_gate_out(rect_gate_out),
  .discharge_out(discharge_out), .ready_out(ready_out),
  .lamp_current_ua_out(lamp_current_ua_out), .lamp_test_out(lamp_test_out));

// ===== testbench/ifs_fieldbus_master.sv
/*
  Fieldbus master model speaking AHB-Lite single word transfers.
  Assumes its tasks are entered just after a rising clock edge.
*/
`timescale 1ns/100ps
module ifs_fieldbus_master (
  input wire clk_sys_in,
  input wire hready_in,
  input wire [31:0] hrdata_in,
  output reg hsel_out,
  output reg [31:0] haddr_out,
  output reg [1:0] htrans_out,
  output reg hwrite_out,
  output reg [2:0] hsize_out,
  output reg [31:0] hwdata_out,
  output reg hung_out
);
  initial begin
    {hsel_out, haddr_out, htrans_out, hwrite_out, hwdata_out} = 0;
    hsize_out = 3'h2;
    hung_out = 1'b0;
  end
  task wait_ready;
    integer n;
    begin
      n = 0;
      @(posedge clk_sys_in);
      while (!hready_in && n < 100) begin
        n = n + 1;
        @(posedge clk_sys_in);
      end
      if (n >= 100) hung_out = 1'b1;
    end
  endtask
  // Start and stop go through one enable bit of a single write.
  task xfer(input wr, input [11:0] a, input [31:0] d, output [31:0] q);
    begin
      hsel_out <= 1'b1;
      haddr_out <= {20'h0, a};
      hwrite_out <= wr;
      htrans_out <= 2'b10;
      wait_ready;
      htrans_out <= 2'b00;
      hwdata_out <= d;
      wait_ready;
      q = hrdata_in;
    end
  endtask
endmodule

// ===== testbench/ifs_supervisor_tb.sv
/*
  Self-checking bench of the infeed fault supervisor.
  Assumes shortened timing parameters and the fieldbus master model.
*/
`timescale 1ns/100ps
`include "ifs_regs.vh"
module ifs_supervisor_tb;
  reg clk_sys_in, rstn_in;
  reg signed [15:0] volt, curr, sink, rect, sup, freq;
  reg [11:0] flags;
  reg [31:0] rd_q, rnd;
  reg [7:0] lv;
  integer fails, comparisons, k;
  wire hsel, hwrite, hready, hresp, gate, disch, ready, ltest, hung;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire [14:0] lamp;
  ifs_fieldbus_master m (.clk_sys_in(clk_sys_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
    .hwdata_out(hwdata), .hung_out(hung));
  ifs_supervisor #(.TEST_CYC(20), .DISCH_CYC(30), .OL_CYC(16)) uut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .bus_volt_in(volt), .bus_curr_in(curr), .sink_temp_in(sink),
    .rect_temp_in(rect), .supply_dv_in(sup), .freq_dhz_in(freq),
    .phase_unknown_in(flags[0]), .grid_lost_in(flags[1]),
    .fan_fault_in(flags[2]), .gnd_fault_in(flags[3]),
    .brake_short_in(flags[4]), .brake_temp_in(flags[5]),
    .brake_test_fail_in(flags[6]), .brake_test_done_in(flags[7]),
    .charging_in(flags[8]), .gating_full_in(flags[9]),
    .lamp_open_in(flags[10]), .lamp_short_in(flags[11]),
    .rect_gate_out(gate), .discharge_out(disch), .ready_out(ready),
    .lamp_current_ua_out(lamp), .lamp_test_out(ltest));
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge hung) begin
    fails = fails + 1;
    tally_and_finish;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [14:0] lamp_ua(input [7:0] v);
    lamp_ua = v * 20000 / 255;
  endfunction
  task tally_and_finish;
    begin
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wait_on(input integer w, input v);
    integer n;
    begin
      n = 0;
      @(posedge clk_sys_in);
      while ((w == 0 ? gate : w == 1 ? ready : ltest) !== v && n < 2000) begin
        n = n + 1;
        @(posedge clk_sys_in);
      end
      if (n >= 2000) begin
        fails = fails + 1;
        tally_and_finish;
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    m.xfer(1'b1, a, d, rd_q);
  endtask
  task stat(input [18:0] e);
    begin
      m.xfer(1'b0, `IFS_ADDR_STAT, 32'h0, rd_q);
      check("status", e, rd_q[18:0]);
    end
  endtask
  // Disable, then enable again: the rising enable clears the latch.
  task restart;
    begin
      @(posedge clk_sys_in);
      volt <= 16'sd30;
      wr(`IFS_ADDR_CTRL, 32'h0);
      wr(`IFS_ADDR_CTRL, 32'h1);
      wait_on(0, 1'b1);
      volt <= 16'sd600;
      wait_on(1, 1'b1);
    end
  endtask
  task fault(input integer f, input on);
    case (f)
      0: sup <= on ? 16'sd150 : 16'sd240;
      1: flags[4] <= on;
      2: flags[5] <= on;
      3: flags[0] <= on;
      4: curr <= on ? 16'sd200 : 16'sd10;
      5: volt <= on ? 16'sd950 : 16'sd600;
      6: volt <= on ? 16'sd200 : 16'sd600;
      7: rect <= on ? 16'sd120 : 16'sd40;
      8: sink <= on ? 16'sd80 : 16'sd40;
      9: flags[1] <= on;
      10: freq <= on ? 16'sd400 : 16'sd500;
      11: flags[6] <= on;
      default: curr <= on ? 16'sd40 : 16'sd10;
    endcase
  endtask
  initial begin
    fails = 0;
    comparisons = 0;
    rnd = 32'h3da06660;
    {rstn_in, curr} = {1'b0, 16'sd10};
    {volt, sink, rect} = {16'sd30, 16'sd40, 16'sd40};
    {sup, freq, flags} = {16'sd240, 16'sd500, 12'h280};
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    check("reset", 4'b0100, {gate, disch, ready, ltest});
    restart;
    m.xfer(1'b0, 12'h100, 32'h0, rd_q);
    check("unmapped", 32'h0, rd_q);
    flags[3:2] <= 2'b11;
    repeat (4) @(posedge clk_sys_in);
    stat(19'h42000);
    check("warn run", 2'b11, {gate, ready});
    flags[3:2] <= 2'b00;
    repeat (4) @(posedge clk_sys_in);
    stat(19'h0);
    wr(`IFS_ADDR_CTRL, 32'h0);
    repeat (40) @(posedge clk_sys_in);
    stat(19'h20000);
    restart;
    for (k = 0; k < 13; k = k + 1) begin
      fault(k, 1'b1);
      repeat (30) @(posedge clk_sys_in);
      stat(19'h1 << k);
      check("gate", 0, gate);
      check("discharge", k != 1, disch);
      fault(k, 1'b0);
      restart;
    end
    fault(5, 1'b1);
    fault(4, 1'b1);
    repeat (30) @(posedge clk_sys_in);
    stat(19'h10);
    fault(4, 1'b0);
    fault(5, 1'b0);
    @(posedge clk_sys_in);
    volt <= 16'sd80;
    wr(`IFS_ADDR_CTRL, 32'h0);
    wr(`IFS_ADDR_CTRL, 32'h1);
    repeat (10) @(posedge clk_sys_in);
    stat(19'h10000);
    check("gate", 0, gate);
    restart;
    rnd = lfsr(rnd);
    lv = rnd[7:0] | 8'h01;
    flags[10] <= 1'b1;
    wr(`IFS_ADDR_LAMP, {24'h0, lv});
    wait_on(2, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    check("test lamp", lamp_ua(8'h80), lamp);
    wait_on(2, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    check("lamp", lamp_ua(lv), lamp);
    stat(19'h4000);
    check("run", 1, ready);
    flags[11:10] <= 2'b10;
    wr(`IFS_ADDR_LAMP, 32'hff);
    repeat (3) @(posedge clk_sys_in);
    check("no test", 0, ltest);
    check("lamp", 20000, lamp);
    m.xfer(1'b0, `IFS_ADDR_CODE, 32'h0, rd_q);
    check("lamp code", lamp_ua(8'hff), rd_q);
    stat(19'h4000);
    wr(`IFS_ADDR_LAMP, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    check("lamp", 0, lamp);
    curr <= -16'sd20;
    repeat (1000) @(posedge clk_sys_in);
    m.xfer(1'b0, `IFS_ADDR_CURR, 32'h0, rd_q);
    check("current", -32'sd20, rd_q);
    m.xfer(1'b0, `IFS_ADDR_PWR, 32'h0, rd_q);
    check("power", -32'sd12, rd_q);
    check("bus hang", 0, hung);
    tally_and_finish;
  end
endmodule
